/* File: mfr_decoder_cfg.svh */
// Command codes, field positions, reset values and timing counts for the command decoder
`ifndef MFR_DECODER_CFG_SVH
`define MFR_DECODER_CFG_SVH
`define CMD_CLEAR_PEAKS 8'hE3
`define CMD_FAULT_LOG_STORE 8'hEA
`define CMD_FAULT_LOG_CLEAR 8'hEC
`define CMD_FAULT_LOG_READ 8'hEE
`define CMD_SHARED_STATUS 8'hEF
`define CMD_COMPARE_ALL 8'hF0
`define CMD_DIE_TEMP_PEAK 8'hF4
`define CMD_PHASING_CFG 8'hF5
`define CMD_SENSE_TC 8'hF6
`define CMD_TEMP_SLOPE 8'hF8
`define CMD_TEMP_OFFSET 8'hF9
`define CMD_RAIL_ADDR 8'hFA
`define CMD_DEV_RESET 8'hFD
`define RST_PHASING_CFG 8'h10
`define RST_SENSE_TC 16'h0000
`define RST_TEMP_SLOPE 16'h4000
`define RST_TEMP_OFFSET 16'h8000
`define RST_RAIL_ADDR 8'h80
`define RST_PWM_MODE 8'hC1
`define RST_DIE_PEAK 16'h8000
`define CML_RO_WRITE_BIT 6
`define PWM_ILIM_RANGE_BIT 7
`define PWM_VRANGE_BIT 1
`define FAULT_LOG_DEPTH 16
`define FAULT_LOG_AW 4
`define NVM_DEPTH 32
`define NVM_AW 5
`define NVM_SLOT_LOG 5'h10
`define NVM_SLOT_CFG 5'h00
`define CFG_WORDS 8
`define NVM_OP_CYCLES 8'h10
`define TC_FULL_SCALE 16'h0400
`endif

/* File: mfr_decoder_pkg.sv */
// Types shared by the manufacturer command decoder
package mfr_decoder_pkg;
	typedef enum logic [1:0] {XFER_SEND, XFER_READ, XFER_WRITE} xfer_kind_t;
	typedef struct packed {
		logic valid;
		xfer_kind_t kind;
		logic [7:0] code;
		logic [15:0] wdata;
	} cmd_req_t;
	typedef struct packed {
		logic valid;
		logic [15:0] rdata;
		logic rejected;
	} cmd_rsp_t;
	typedef struct packed {
		logic ilim_high_range;
		logic vout_high_range;
		logic [2:0] ilim_level;
	} loop_ctl_t;
endpackage

/* File: nvm_store.sv */
// Small word memory standing in for the nonvolatile array, registered read data
`timescale 1ns/1ns
`include "mfr_decoder_cfg.svh"
module nvm_store (
	input wire logic clk,
	input wire logic we,
	input wire logic [`NVM_AW-1:0] waddr,
	input wire logic [15:0] wdata,
	input wire logic [`NVM_AW-1:0] raddr,
	output logic [15:0] rdata
);
	logic [15:0] mem [`NVM_DEPTH];

	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule

/* File: mfr_command_decoder.sv */
// Manufacturer-range command decoder with config words, fault log and peak tracking
`timescale 1ns/1ns
`include "mfr_decoder_cfg.svh"
module mfr_command_decoder
	import mfr_decoder_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// Command port from bus target
	input wire cmd_req_t CMD_REQ,
	input wire logic PAGE_SEL,
	input wire logic STORE_ALL,
	input wire logic RESTORE_ALL,
	input wire logic [7:0] PWM_MODE_WR,
	input wire logic PWM_MODE_WE,
	input wire logic [2:0] ILIM_LEVEL,
	output cmd_rsp_t CMD_RSP,
	output logic CMD_BUSY,
	// Telemetry and fault inputs
	input wire logic [15:0] DIE_TEMP,
	input wire logic DIE_TEMP_VALID,
	input wire logic [7:0] FAULT_EVENT,
	input wire logic FAULT_EVENT_VALID,
	input wire logic [11:0] SENSE_CURRENT,
	input wire logic [15:0] SENSE_TEMP_DELTA,
	input wire logic [11:0] ILIM_BASE,
	// Loop control and status
	output loop_ctl_t LOOP_CTL,
	output logic [11:0] ILIM_SCALED,
	output logic PEAK_TRIP,
	output logic [7:0] COMM_MEMORY_LOGIC_STATUS,
	output logic COMPARE_MISMATCH,
	output logic SOFT_RESET_REQ
);
	typedef enum logic [2:0] {IDLE, LOG_STORE, LOG_CLEAR, CFG_STORE, CFG_RESTORE, CMP_RUN, RST_HOLD} nvm_state_t;

	function automatic logic [15:0] peak_of(input logic [15:0] cur, input logic [15:0] smp);
		// Linear mantissa comparison suffices within one exponent band
		peak_of = ($signed(smp[10:0]) > $signed(cur[10:0])) ? smp : cur;
	endfunction

	function automatic logic is_documented(input logic [7:0] c);
		is_documented = (c == `CMD_CLEAR_PEAKS) || (c == `CMD_FAULT_LOG_STORE) || (c == `CMD_FAULT_LOG_CLEAR) ||
			(c == `CMD_FAULT_LOG_READ) || (c == `CMD_SHARED_STATUS) || (c == `CMD_COMPARE_ALL) ||
			(c == `CMD_DIE_TEMP_PEAK) || (c == `CMD_PHASING_CFG) || (c == `CMD_SENSE_TC) ||
			(c == `CMD_TEMP_SLOPE) || (c == `CMD_TEMP_OFFSET) || (c == `CMD_RAIL_ADDR) || (c == `CMD_DEV_RESET);
	endfunction

	nvm_state_t state_ff;
	logic [7:0] phasing_ff;
	logic [15:0] sense_tc_ff [2];
	logic [15:0] slope_ff [2];
	logic [15:0] offset_ff [2];
	logic [7:0] rail_ff [2];
	logic [7:0] pwm_mode_ff;
	logic [15:0] die_peak_ff;
	logic [7:0] log_ram_ff [`FAULT_LOG_DEPTH];
	logic [`FAULT_LOG_AW-1:0] log_wptr_ff;
	logic [`FAULT_LOG_AW-1:0] log_rptr_ff;
	logic [`NVM_AW-1:0] step_ff;
	logic [7:0] wait_ff;
	logic cmp_diff_ff;
	logic cml_ff;
	logic soft_rst_ff;
	logic [15:0] nvm_rdata;
	logic nvm_we;
	logic [`NVM_AW-1:0] nvm_waddr;
	logic [`NVM_AW-1:0] nvm_raddr;
	logic [15:0] nvm_wdata;
	logic [15:0] cfg_word;
	logic [15:0] rd_mux;
	logic req_send, req_read, req_write;

	assign req_send = CMD_REQ.valid && CMD_REQ.kind == XFER_SEND && state_ff == IDLE;
	assign req_read = CMD_REQ.valid && CMD_REQ.kind == XFER_READ;
	assign req_write = CMD_REQ.valid && CMD_REQ.kind == XFER_WRITE && state_ff == IDLE;

	// Config snapshot layout in nonvolatile: one word per step
	always_comb begin
		case (step_ff[2:0])
			3'h0: cfg_word = {8'h00, phasing_ff};
			3'h1: cfg_word = sense_tc_ff[0];
			3'h2: cfg_word = sense_tc_ff[1];
			3'h3: cfg_word = slope_ff[0];
			3'h4: cfg_word = slope_ff[1];
			3'h5: cfg_word = offset_ff[0];
			3'h6: cfg_word = offset_ff[1];
			default: cfg_word = {rail_ff[1], rail_ff[0]};
		endcase
	end

	always_comb begin
		nvm_we = 1'b0;
		nvm_waddr = step_ff;
		nvm_wdata = 16'h0000;
		nvm_raddr = step_ff;
		case (state_ff)
			LOG_STORE: begin
				nvm_we = wait_ff == 8'h00;
				nvm_waddr = `NVM_SLOT_LOG + {1'b0, step_ff[`FAULT_LOG_AW-1:0]};
				nvm_wdata = {8'h00, log_ram_ff[step_ff[`FAULT_LOG_AW-1:0]]};
			end
			LOG_CLEAR: begin
				nvm_we = wait_ff == 8'h00;
				nvm_waddr = `NVM_SLOT_LOG + {1'b0, step_ff[`FAULT_LOG_AW-1:0]};
				nvm_wdata = 16'hFFFF;
			end
			CFG_STORE: begin
				nvm_we = wait_ff == 8'h00;
				nvm_waddr = `NVM_SLOT_CFG + step_ff;
				nvm_wdata = cfg_word;
			end
			default: begin
				nvm_raddr = `NVM_SLOT_CFG + step_ff;
			end
		endcase
	end

	nvm_store nvm_store_inst (
		.clk(CORE_CLK),
		.we(nvm_we),
		.waddr(nvm_waddr),
		.wdata(nvm_wdata),
		.raddr(nvm_raddr),
		.rdata(nvm_rdata)
	);

	// Nonvolatile sequencer; send-bytes ignored while busy
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			state_ff <= IDLE;
			step_ff <= '0;
			wait_ff <= 8'h00;
		end else begin
			case (state_ff)
				IDLE: begin
					step_ff <= '0;
					wait_ff <= 8'h00;
					if (req_send && CMD_REQ.code == `CMD_FAULT_LOG_STORE) begin
						state_ff <= LOG_STORE;
					end else if (req_send && CMD_REQ.code == `CMD_FAULT_LOG_CLEAR) begin
						state_ff <= LOG_CLEAR;
					end else if (req_send && CMD_REQ.code == `CMD_COMPARE_ALL) begin
						state_ff <= CMP_RUN;
					end else if (req_send && CMD_REQ.code == `CMD_DEV_RESET) begin
						state_ff <= RST_HOLD;
					end else if (STORE_ALL) begin
						state_ff <= CFG_STORE;
					end else if (RESTORE_ALL) begin
						state_ff <= CFG_RESTORE;
					end
				end
				RST_HOLD: begin
					wait_ff <= wait_ff + 8'h01;
					if (wait_ff == `NVM_OP_CYCLES) begin
						state_ff <= IDLE;
					end
				end
				default: begin
					// Each word write models a slow array program time
					wait_ff <= (wait_ff == `NVM_OP_CYCLES) ? 8'h00 : wait_ff + 8'h01;
					if (wait_ff == `NVM_OP_CYCLES) begin
						step_ff <= step_ff + 5'h01;
						if ((state_ff == LOG_STORE || state_ff == LOG_CLEAR) && step_ff == 5'(`FAULT_LOG_DEPTH - 1)) begin
							state_ff <= IDLE;
						end else if (state_ff != LOG_STORE && state_ff != LOG_CLEAR && step_ff == 5'(`CFG_WORDS - 1)) begin
							state_ff <= IDLE;
						end
					end
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cmp_diff_ff <= 1'b0;
		end else if (req_send && CMD_REQ.code == `CMD_COMPARE_ALL) begin
			cmp_diff_ff <= 1'b0;
		end else if (state_ff == CMP_RUN && wait_ff == `NVM_OP_CYCLES - 8'h01 && nvm_rdata != cfg_word) begin
			cmp_diff_ff <= 1'b1;
		end
	end

	// Working configuration; paged copies follow PAGE_SEL
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			phasing_ff <= `RST_PHASING_CFG;
			sense_tc_ff[0] <= `RST_SENSE_TC;
			sense_tc_ff[1] <= `RST_SENSE_TC;
			slope_ff[0] <= `RST_TEMP_SLOPE;
			slope_ff[1] <= `RST_TEMP_SLOPE;
			offset_ff[0] <= `RST_TEMP_OFFSET;
			offset_ff[1] <= `RST_TEMP_OFFSET;
			rail_ff[0] <= `RST_RAIL_ADDR;
			rail_ff[1] <= `RST_RAIL_ADDR;
			pwm_mode_ff <= `RST_PWM_MODE;
		end else if (state_ff == RST_HOLD) begin
			phasing_ff <= `RST_PHASING_CFG;
			sense_tc_ff[0] <= `RST_SENSE_TC;
			sense_tc_ff[1] <= `RST_SENSE_TC;
			slope_ff[0] <= `RST_TEMP_SLOPE;
			slope_ff[1] <= `RST_TEMP_SLOPE;
			offset_ff[0] <= `RST_TEMP_OFFSET;
			offset_ff[1] <= `RST_TEMP_OFFSET;
			rail_ff[0] <= `RST_RAIL_ADDR;
			rail_ff[1] <= `RST_RAIL_ADDR;
			pwm_mode_ff <= `RST_PWM_MODE;
		end else if (state_ff == CFG_RESTORE && wait_ff == `NVM_OP_CYCLES - 8'h01) begin
			case (step_ff[2:0])
				3'h0: phasing_ff <= nvm_rdata[7:0];
				3'h1: sense_tc_ff[0] <= nvm_rdata;
				3'h2: sense_tc_ff[1] <= nvm_rdata;
				3'h3: slope_ff[0] <= nvm_rdata;
				3'h4: slope_ff[1] <= nvm_rdata;
				3'h5: offset_ff[0] <= nvm_rdata;
				3'h6: offset_ff[1] <= nvm_rdata;
				default: begin
					rail_ff[0] <= nvm_rdata[7:0];
					rail_ff[1] <= nvm_rdata[15:8];
				end
			endcase
		end else begin
			if (PWM_MODE_WE) begin
				pwm_mode_ff <= PWM_MODE_WR;
			end
			if (req_write) begin
				if (CMD_REQ.code == `CMD_PHASING_CFG) begin
					phasing_ff <= CMD_REQ.wdata[7:0];
				end else if (CMD_REQ.code == `CMD_SENSE_TC) begin
					sense_tc_ff[PAGE_SEL] <= CMD_REQ.wdata;
				end else if (CMD_REQ.code == `CMD_TEMP_SLOPE) begin
					slope_ff[PAGE_SEL] <= CMD_REQ.wdata;
				end else if (CMD_REQ.code == `CMD_TEMP_OFFSET) begin
					offset_ff[PAGE_SEL] <= CMD_REQ.wdata;
				end else if (CMD_REQ.code == `CMD_RAIL_ADDR) begin
					rail_ff[PAGE_SEL] <= CMD_REQ.wdata[7:0];
				end
			end
		end
	end

	// Fault log RAM: events append, block read walks it
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			log_wptr_ff <= '0;
			log_rptr_ff <= '0;
			for (int i = 0; i < `FAULT_LOG_DEPTH; i++) begin
				log_ram_ff[i] <= 8'h00;
			end
		end else begin
			if (FAULT_EVENT_VALID) begin
				log_ram_ff[log_wptr_ff] <= FAULT_EVENT;
				log_wptr_ff <= log_wptr_ff + 4'h1;
			end
			if (req_read && CMD_REQ.code == `CMD_FAULT_LOG_READ) begin
				log_rptr_ff <= log_rptr_ff + 4'h1;
			end else if (CMD_REQ.valid && CMD_REQ.code != `CMD_FAULT_LOG_READ) begin
				log_rptr_ff <= '0;
			end
		end
	end

	// Peak tracker; sample wins over clear in same cycle
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			die_peak_ff <= `RST_DIE_PEAK;
		end else if (DIE_TEMP_VALID && req_send && CMD_REQ.code == `CMD_CLEAR_PEAKS) begin
			die_peak_ff <= DIE_TEMP;
		end else if (req_send && CMD_REQ.code == `CMD_CLEAR_PEAKS) begin
			die_peak_ff <= `RST_DIE_PEAK;
		end else if (DIE_TEMP_VALID) begin
			die_peak_ff <= peak_of(die_peak_ff, DIE_TEMP);
		end
	end

	always_comb begin
		// Undocumented codes return zero; they still rewind the fault log read pointer, and undocumented writes set the CML bit
		rd_mux = 16'h0000;
		if (CMD_REQ.code == `CMD_FAULT_LOG_READ) begin
			rd_mux = {8'h00, log_ram_ff[log_rptr_ff]};
		end else if (CMD_REQ.code == `CMD_SHARED_STATUS) begin
			rd_mux = {8'h00, state_ff == IDLE, state_ff != IDLE, cmp_diff_ff, cml_ff, 4'h0};
		end else if (CMD_REQ.code == `CMD_DIE_TEMP_PEAK) begin
			rd_mux = die_peak_ff;
		end else if (CMD_REQ.code == `CMD_PHASING_CFG) begin
			rd_mux = {8'h00, phasing_ff};
		end else if (CMD_REQ.code == `CMD_SENSE_TC) begin
			rd_mux = sense_tc_ff[PAGE_SEL];
		end else if (CMD_REQ.code == `CMD_TEMP_SLOPE) begin
			rd_mux = slope_ff[PAGE_SEL];
		end else if (CMD_REQ.code == `CMD_TEMP_OFFSET) begin
			rd_mux = offset_ff[PAGE_SEL];
		end else if (CMD_REQ.code == `CMD_RAIL_ADDR) begin
			rd_mux = {8'h00, rail_ff[PAGE_SEL]};
		end
	end

	// Response, status and loop outputs
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			CMD_RSP <= '0;
			cml_ff <= 1'b0;
		end else begin
			CMD_RSP.valid <= CMD_REQ.valid;
			CMD_RSP.rdata <= req_read ? rd_mux : 16'h0000;
			CMD_RSP.rejected <= CMD_REQ.valid && CMD_REQ.kind == XFER_WRITE && !is_documented(CMD_REQ.code);
			if (CMD_REQ.valid && CMD_REQ.kind == XFER_WRITE && !is_documented(CMD_REQ.code)) begin
				cml_ff <= 1'b1;
			end else if (state_ff == RST_HOLD) begin
				cml_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			LOOP_CTL <= '0;
			ILIM_SCALED <= 12'h000;
			PEAK_TRIP <= 1'b0;
			COMM_MEMORY_LOGIC_STATUS <= 8'h00;
			COMPARE_MISMATCH <= 1'b0;
			CMD_BUSY <= 1'b0;
			soft_rst_ff <= 1'b0;
			SOFT_RESET_REQ <= 1'b0;
		end else begin
			LOOP_CTL.ilim_high_range <= pwm_mode_ff[`PWM_ILIM_RANGE_BIT];
			LOOP_CTL.vout_high_range <= pwm_mode_ff[`PWM_VRANGE_BIT];
			LOOP_CTL.ilim_level <= ILIM_LEVEL;
			// Coefficient in 1/1048576 per degree; truncated to keep it one multiply
			ILIM_SCALED <= 12'(({16'h0000, ILIM_BASE, 4'h0} * ({16'h0000, `TC_FULL_SCALE} +
				{16'h0000, sense_tc_ff[PAGE_SEL]} * {16'h0000, SENSE_TEMP_DELTA} / 32'h0000_0400)) >> 14);
			PEAK_TRIP <= SENSE_CURRENT >= ILIM_SCALED;
			COMM_MEMORY_LOGIC_STATUS <= {1'b0, cml_ff, 6'h00};
			COMPARE_MISMATCH <= cmp_diff_ff;
			CMD_BUSY <= state_ff != IDLE;
			soft_rst_ff <= state_ff == RST_HOLD;
			SOFT_RESET_REQ <= soft_rst_ff;
		end
	end

	property p_cml_on_bad_write;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(CMD_REQ.valid && CMD_REQ.kind == XFER_WRITE && !is_documented(CMD_REQ.code)) |=> ##1 COMM_MEMORY_LOGIC_STATUS[6];
	endproperty
	a_cml_on_bad_write: assert property (p_cml_on_bad_write) else $error("bad write did not set status bit 6");

	property p_phasing_write;
		@(posedge CORE_CLK) disable iff (!RST_N)
		(req_write && CMD_REQ.code == `CMD_PHASING_CFG && !PWM_MODE_WE) |=> phasing_ff == $past(CMD_REQ.wdata[7:0]);
	endproperty
	a_phasing_write: assert property (p_phasing_write) else $error("phasing write lost");

	sequence s_clear_cmd;
		req_send && CMD_REQ.code == `CMD_CLEAR_PEAKS && !DIE_TEMP_VALID;
	endsequence
	property p_clear_peaks;
		@(posedge CORE_CLK) disable iff (!RST_N)
		s_clear_cmd |=> die_peak_ff == `RST_DIE_PEAK;
	endproperty
	a_clear_peaks: assert property (p_clear_peaks) else $error("peak not cleared");

	property p_range_bit;
		@(posedge CORE_CLK) disable iff (!RST_N)
		$changed(pwm_mode_ff) |=> LOOP_CTL.ilim_high_range == $past(pwm_mode_ff[7]) &&
			LOOP_CTL.vout_high_range == $past(pwm_mode_ff[1]);
	endproperty
	a_range_bit: assert property (p_range_bit) else $error("range bits not applied");

	property p_vrange;
		@(posedge CORE_CLK) disable iff (!RST_N)
		PWM_MODE_WE && state_ff == IDLE |=> ##1 LOOP_CTL.vout_high_range == $past(PWM_MODE_WR[1], 2);
	endproperty
	a_vrange: assert property (p_vrange) else $error("voltage range bit wrong");

	property p_peak_monotone;
		@(posedge CORE_CLK) disable iff (!RST_N)
		DIE_TEMP_VALID && !req_send |=> $signed(die_peak_ff[10:0]) >= $signed($past(DIE_TEMP[10:0]));
	endproperty
	a_peak_monotone: assert property (p_peak_monotone) else $error("die peak below sample");

	sequence s_store_start;
		req_send && CMD_REQ.code == `CMD_FAULT_LOG_STORE;
	endsequence
	property p_log_store;
		@(posedge CORE_CLK) disable iff (!RST_N)
		// First word is programmed in the very cycle the store state is entered
		s_store_start |=> state_ff == LOG_STORE && nvm_we;
	endproperty
	a_log_store: assert property (p_log_store) else $error("fault log store did not start");

	property p_log_clear;
		@(posedge CORE_CLK) disable iff (!RST_N)
		req_send && CMD_REQ.code == `CMD_FAULT_LOG_CLEAR |=> state_ff == LOG_CLEAR ##1 nvm_wdata == 16'hFFFF;
	endproperty
	a_log_clear: assert property (p_log_clear) else $error("fault log clear did not start");

	property p_reset_cmd;
		@(posedge CORE_CLK) disable iff (!RST_N)
		req_send && CMD_REQ.code == `CMD_DEV_RESET |=> ##2 SOFT_RESET_REQ;
	endproperty
	a_reset_cmd: assert property (p_reset_cmd) else $error("reset request missing");

	property p_undoc_read;
		@(posedge CORE_CLK) disable iff (!RST_N)
		req_read && !is_documented(CMD_REQ.code) |=> CMD_RSP.rdata == 16'h0000 && !CMD_RSP.rejected;
	endproperty
	a_undoc_read: assert property (p_undoc_read) else $error("undocumented read misbehaved");
endmodule

/* File: pmbus_host_model.sv */
// Host bus controller model that issues command transfers to the decoder
`timescale 1ns/1ns
module pmbus_host_model
	import mfr_decoder_pkg::*;
(
	// Clock and decoder handshake
	input wire logic clk,
	input wire cmd_rsp_t rsp,
	input wire logic busy,
	// Request to decoder
	output cmd_req_t req
);
	initial req = {1'b0, XFER_READ, 8'h00, 16'h0000};

	task automatic xfer(input xfer_kind_t kind, input logic [7:0] code, input logic [15:0] wdata,
		output cmd_rsp_t got);
		int n;
		n = 0;
		got = '0;
		@(posedge clk);
		#1;
		// Sends and writes are dropped while busy, so hold them back
		while (kind != XFER_READ && busy !== 1'b0 && n < 4000) begin
			@(posedge clk);
			#1;
			n++;
		end
		req = {1'b1, kind, code, wdata};
		@(posedge clk);
		#1;
		got = rsp;
		// Released lines carry the inverse so stale values cannot pass
		req = {1'b0, kind, ~code, ~wdata};
	endtask
endmodule

/* File: pmbus_mfr_command_decoder_test.sv */
// Self-checking bench for the manufacturer command decoder
`timescale 1ns/1ns
`include "mfr_decoder_cfg.svh"
module pmbus_mfr_command_decoder_test import mfr_decoder_pkg::*;;
	logic core_clk = 1'b0, rst_n = 1'b0, page_sel = 1'b0, store_all = 1'b0, restore_all = 1'b0;
	logic [7:0] pwm_mode_wr = 8'h00, fault_event = 8'h00, cml_status;
	logic pwm_mode_we = 1'b0, die_temp_valid = 1'b0, fault_event_valid = 1'b0;
	logic [2:0] ilim_level = 3'h0;
	logic [15:0] die_temp = 16'h0000, sense_temp_delta = 16'h0000;
	logic [11:0] sense_current = 12'h000, ilim_base = 12'h000, ilim_scaled;
	cmd_req_t cmd_req;
	cmd_rsp_t cmd_rsp;
	loop_ctl_t loop_ctl;
	logic cmd_busy, peak_trip, compare_mismatch, soft_reset_req;
	int mismatches = 0, n_tests = 0;

	always #25 core_clk = ~core_clk;

	mfr_command_decoder mfr_command_decoder_inst (.CORE_CLK(core_clk), .RST_N(rst_n), .CMD_REQ(cmd_req),
		.PAGE_SEL(page_sel), .STORE_ALL(store_all), .RESTORE_ALL(restore_all), .PWM_MODE_WR(pwm_mode_wr),
		.PWM_MODE_WE(pwm_mode_we), .ILIM_LEVEL(ilim_level), .CMD_RSP(cmd_rsp), .CMD_BUSY(cmd_busy),
		.DIE_TEMP(die_temp), .DIE_TEMP_VALID(die_temp_valid), .FAULT_EVENT(fault_event),
		.FAULT_EVENT_VALID(fault_event_valid), .SENSE_CURRENT(sense_current),
		.SENSE_TEMP_DELTA(sense_temp_delta), .ILIM_BASE(ilim_base), .LOOP_CTL(loop_ctl),
		.ILIM_SCALED(ilim_scaled), .PEAK_TRIP(peak_trip), .COMM_MEMORY_LOGIC_STATUS(cml_status),
		.COMPARE_MISMATCH(compare_mismatch), .SOFT_RESET_REQ(soft_reset_req));
	pmbus_host_model pmbus_host_model_inst (.clk(core_clk), .rsp(cmd_rsp), .busy(cmd_busy), .req(cmd_req));

	task automatic tick(input int n = 1);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk1(input string what, input logic exp, input logic got);
		chk(what, {15'h0, exp}, {15'h0, got});
	endtask
	task automatic xf(input xfer_kind_t k, input logic [7:0] c, input logic [15:0] d, output cmd_rsp_t r);
		pmbus_host_model_inst.xfer(k, c, d, r);
		chk1("rsp valid", 1'b1, r.valid);
	endtask
	task automatic rd_chk(input logic [7:0] c, input logic [15:0] e, input logic [15:0] m, input string what);
		cmd_rsp_t r;
		xf(XFER_READ, c, 16'h0000, r);
		chk(what, e & m, r.rdata & m);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		tick(3);
		while (cmd_busy !== 1'b0 && n < 4000) begin
			tick();
			n++;
		end
		chk1("idle", 1'b0, cmd_busy);
	endtask
	task automatic pulse_store(input logic restore);
		store_all = ~restore;
		restore_all = restore;
		tick();
		store_all = 1'b0;
		restore_all = 1'b0;
		wait_idle();
	endtask

	task automatic t_defaults;
		logic [7:0] codes [5] = '{`CMD_PHASING_CFG, `CMD_SENSE_TC, `CMD_TEMP_SLOPE, `CMD_TEMP_OFFSET, `CMD_RAIL_ADDR};
		logic [15:0] vals [5] = '{{8'h00, `RST_PHASING_CFG}, `RST_SENSE_TC, `RST_TEMP_SLOPE, `RST_TEMP_OFFSET,
			{8'h00, `RST_RAIL_ADDR}};
		logic [15:0] masks [5] = '{16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h00FF};
		for (int i = 0; i < 5; i++) begin
			rd_chk(codes[i], vals[i], masks[i], "reset value");
		end
		chk1("limit range", 1'b1, loop_ctl.ilim_high_range);
		chk1("volt range", 1'b0, loop_ctl.vout_high_range);
	endtask
	task automatic t_fault_log;
		logic [7:0] ev [3] = '{8'hA1, 8'hB2, 8'hC3};
		cmd_rsp_t r;
		foreach (ev[i]) begin
			fault_event = ev[i];
			fault_event_valid = 1'b1;
			tick();
		end
		fault_event_valid = 1'b0;
		xf(XFER_SEND, `CMD_FAULT_LOG_STORE, 16'h0000, r);
		tick();
		chk1("store busy", 1'b1, cmd_busy);
		wait_idle();
		foreach (ev[i]) begin
			rd_chk(`CMD_FAULT_LOG_READ, {8'h00, ev[i]}, 16'h00FF, "log byte");
		end
		xf(XFER_SEND, `CMD_FAULT_LOG_CLEAR, 16'h0000, r);
		tick();
		chk1("clear busy", 1'b1, cmd_busy);
		wait_idle();
	endtask
	task automatic t_paging;
		cmd_rsp_t r;
		xf(XFER_WRITE, `CMD_SENSE_TC, 16'h1234, r);
		xf(XFER_WRITE, `CMD_PHASING_CFG, 16'h005A, r);
		page_sel = 1'b1;
		rd_chk(`CMD_SENSE_TC, `RST_SENSE_TC, 16'hFFFF, "other page");
		rd_chk(`CMD_PHASING_CFG, 16'h005A, 16'h00FF, "unpaged");
		xf(XFER_WRITE, `CMD_RAIL_ADDR, 16'h0033, r);
		rd_chk(`CMD_RAIL_ADDR, 16'h0033, 16'h00FF, "rail page1");
		page_sel = 1'b0;
		rd_chk(`CMD_SENSE_TC, 16'h1234, 16'hFFFF, "own page");
		rd_chk(`CMD_RAIL_ADDR, {8'h00, `RST_RAIL_ADDR}, 16'h00FF, "rail page0");
	endtask
	task automatic t_refusal;
		cmd_rsp_t r;
		xf(XFER_READ, 8'hFB, 16'h0000, r);
		rd_chk(`CMD_PHASING_CFG, 16'h005A, 16'h00FF, "undisturbed");
		xf(XFER_WRITE, 8'hFE, 16'hA5A5, r);
		chk1("rejected", 1'b1, r.rejected);
		tick(2);
		chk1("cml bit", 1'b1, cml_status[`CML_RO_WRITE_BIT]);
		rd_chk(`CMD_SHARED_STATUS, 16'h0090, 16'h00D0, "shared status");
	endtask
	task automatic t_peak;
		logic [15:0] s [3] = '{16'h0010, 16'h0030, 16'h0020};
		cmd_rsp_t r;
		foreach (s[i]) begin
			die_temp = s[i];
			die_temp_valid = 1'b1;
			tick();
		end
		die_temp_valid = 1'b0;
		tick();
		rd_chk(`CMD_DIE_TEMP_PEAK, 16'h0030, 16'hFFFF, "die peak");
		xf(XFER_SEND, `CMD_CLEAR_PEAKS, 16'h0000, r);
		tick(2);
		rd_chk(`CMD_DIE_TEMP_PEAK, `RST_DIE_PEAK, 16'hFFFF, "peak cleared");
	endtask
	task automatic t_nvm;
		cmd_rsp_t r;
		xf(XFER_WRITE, `CMD_PHASING_CFG, 16'h0022, r);
		pulse_store(1'b0);
		xf(XFER_WRITE, `CMD_PHASING_CFG, 16'h0033, r);
		xf(XFER_SEND, `CMD_COMPARE_ALL, 16'h0000, r);
		wait_idle();
		chk1("mismatch", 1'b1, compare_mismatch);
		rd_chk(`CMD_SHARED_STATUS, 16'h0020, 16'h0020, "status mismatch");
		pulse_store(1'b1);
		rd_chk(`CMD_PHASING_CFG, 16'h0022, 16'h00FF, "restored");
		xf(XFER_SEND, `CMD_COMPARE_ALL, 16'h0000, r);
		wait_idle();
		chk1("match", 1'b0, compare_mismatch);
	endtask
	task automatic t_loop;
		pwm_mode_wr = 8'h82;
		pwm_mode_we = 1'b1;
		tick();
		pwm_mode_we = 1'b0;
		for (int i = 0; i < 8; i++) begin
			ilim_level = 3'(i);
			tick(2);
			chk("loop ctl", {11'h0, 2'b11, 3'(i)}, {11'h0, loop_ctl});
		end
		pwm_mode_wr = 8'h00;
		pwm_mode_we = 1'b1;
		tick();
		pwm_mode_we = 1'b0;
		tick(2);
		chk("ranges low", 16'h0007, {11'h0, loop_ctl});
	endtask
	task automatic t_limit;
		cmd_rsp_t r;
		ilim_base = 12'h100;
		sense_current = 12'h0FF;
		tick(4);
		chk("scaled", 16'h0100, {4'h0, ilim_scaled});
		chk1("no trip", 1'b0, peak_trip);
		sense_current = 12'h100;
		tick(4);
		chk1("trip", 1'b1, peak_trip);
		xf(XFER_WRITE, `CMD_SENSE_TC, 16'h0400, r);
		page_sel = 1'b1;
		xf(XFER_WRITE, `CMD_SENSE_TC, 16'h0400, r);
		page_sel = 1'b0;
		sense_temp_delta = 16'h0010;
		tick(4);
		chk("rescaled", 16'h0104, {4'h0, ilim_scaled});
		chk1("trip after rescale", 1'b0, peak_trip);
	endtask
	task automatic t_reset;
		cmd_rsp_t r;
		int n;
		n = 0;
		xf(XFER_SEND, `CMD_DEV_RESET, 16'h0000, r);
		while (soft_reset_req !== 1'b1 && n < 5) begin
			tick();
			n++;
		end
		chk1("soft reset", 1'b1, soft_reset_req);
		while (soft_reset_req !== 1'b0 && n < 60) begin
			tick();
			n++;
		end
		wait_idle();
		chk1("cml cleared", 1'b0, cml_status[`CML_RO_WRITE_BIT]);
		rd_chk(`CMD_PHASING_CFG, {8'h00, `RST_PHASING_CFG}, 16'h00FF, "reset config");
	endtask

	task automatic close_out;
		$display("Comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		tick(5);
		rst_n = 1'b1;
		t_defaults();
		t_fault_log();
		t_paging();
		t_refusal();
		t_peak();
		t_nvm();
		t_loop();
		t_limit();
		t_reset();
		close_out();
	end
	// Whole run needs about twelve hundred cycles; the 30000-cycle limit is a generous margin
	initial begin
		#(50 * 30000);
		mismatches++;
		close_out();
	end
endmodule
